// ---- legacy_map_regs.svh ----
`ifndef LEGACY_MAP_REGS_SVH
`define LEGACY_MAP_REGS_SVH
// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_EVENT 8'h04
`define OFS_STATUS 8'h08
`define OFS_FP_STATUS 8'h0C
`define OFS_FP_INSTR 8'h10
`define OFS_FP_DATA 8'h14
`define OFS_PENDING_VEC 8'h18
`define OFS_BUS_TXN 8'h1C
`define OFS_IO_BASE 8'h20
`define OFS_MEM_ADDR 8'h24
// Control bit positions
`define CTL_ATOMIC_INTERCEPT 0
`define CTL_LEGACY_ENV 1
`define CTL_LEGACY_ISA 2
// Interruption status vector numbers
`define VEC_ZERO 8'h00
`define VEC_GATE 8'h01
`define VEC_SYSFLAG 8'h02
`define VEC_LOCK 8'h04
`define CODE_ZERO 16'h0000
// I/O port block size, 64MB, as an address mask
`define IO_BLOCK_MASK 32'hFC000000
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h00000000
`endif

// ---- legacy_map_pkg.sv ----
package legacy_map_pkg;
    // Interruption source codes, taken from the EV_KIND port
    typedef enum logic [3:0] {
        EV_NONE = 4'h0,
        EV_EXT_INT = 4'h1,
        EV_SW_INT = 4'h2,
        EV_BAD_OP = 4'h3,
        EV_GATE = 4'h4,
        EV_SYSFLAG = 4'h5,
        EV_ATOMIC = 4'h6,
        EV_FP_SCALAR = 4'h7,
        EV_FP_PACKED = 4'h8,
        EV_FP_MEDIA = 4'h9,
        EV_ISA_JUMP = 4'hA,
        EV_INVOLUNTARY = 4'hB
    } event_type;
    // Target handler
    typedef enum logic [2:0] {
        H_NONE = 3'h0,
        H_EXTERNAL = 3'h1,
        H_LEGACY_INT = 3'h2,
        H_INTERCEPT_INST = 3'h3,
        H_INTERCEPT_GATE = 3'h4,
        H_INTERCEPT_FLAG = 3'h5,
        H_INTERCEPT_LOCK = 3'h6,
        H_FP_FAULT = 3'h7
    } handler_type;
    // Special bus transactions
    typedef enum logic [2:0] {
        T_NONE = 3'h0,
        T_INT_ACK = 3'h1,
        T_HALT = 3'h2,
        T_SHUTDOWN = 3'h3,
        T_STOP_ACK = 3'h4,
        T_FLUSH = 3'h5,
        T_SYNC = 3'h6
    } bus_txn_type;
    // Interruption status as seen by handler
    typedef struct packed {
        logic [7:0] vector;
        logic [15:0] code;
    } istatus_type;
endpackage

// ---- legacy_map.sv ----
// Behaviour
// - External interrupts: external handler, vector 0 code 0
// - Software interrupt: vector number, trap code
// - Bad opcode: instruction intercept, vector 0
// - Gate transfer: gate intercept, vector 1
// - System flag change: intercept, vector 2
// - Uncached atomic with intercept bit: vector 4
// - Scalar FP faults wait for next FP/media
// - Packed FP faults precise, no pending report
// - ISA jump performs implicit FP wait
// - Involuntary exits skip the FP wait
// - Pending fault loads FP status/instr/data regs
// - Native code never drives atomic pins
// - Atomic and split pins for external locks
// - Native environment ignores mask, error pins
// - I/O block references assert memory/IO flag
// - No system-management interrupt support
// - Ack byte read emits interrupt ack transaction
// - Halt calls emit halt transaction
// - Shutdown transaction only in legacy environment
// - Firmware request emits stop-ack transaction
// - Invalidate instructions emit flush in legacy env
// - Writeback-invalidate also emits sync
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "legacy_map_regs.svh"
module legacy_map
    import legacy_map_pkg::*;
#(
    parameter int IO_BASE_RESET = 32'h00000000
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // AXI4-Lite write
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Pipeline event port
    input wire logic EV_VALID,
    input wire logic [3:0] EV_KIND,
    input wire logic [7:0] EV_VECTOR,
    input wire logic [15:0] EV_CODE,
    input wire logic EV_CACHED,
    input wire logic EV_SPLIT,
    input wire logic [31:0] EV_FP_STATUS,
    input wire logic [31:0] EV_FP_INSTR,
    input wire logic [31:0] EV_FP_DATA,
    // Memory reference port
    input wire logic MEM_VALID,
    input wire logic [31:0] MEM_ADDR,
    // Firmware and cache requests
    input wire logic HALT_REQ,
    input wire logic SHUTDOWN_REQ,
    input wire logic STOP_ACK_REQ,
    input wire logic WRITEBACK_INVALIDATE_INSTRUCTION_EXEC,
    input wire logic CACHE_INVALIDATE_INSTRUCTION_EXEC,
    input wire logic INT_ACK_READ,
    // Legacy pins in
    input wire logic ADDR_BIT20_MASK_PIN,
    input wire logic IGNORE_NUMERIC_ERROR_PIN,
    input wire logic [7:0] INT_ACK_VECTOR,
    // Handler redirection
    output logic REDIRECT,
    output logic [2:0] HANDLER,
    output logic [23:0] ISTATUS,
    // Bus pins
    output logic ATOMIC_PIN,
    output logic SPLIT_ATOMIC_PIN,
    output logic MEM_IO_PIN,
    output logic FP_ERROR_PIN,
    output logic A20_GATE,
    output logic [2:0] BUS_TXN
);
    // All checks run on the core clock, idle during reset
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Software-visible state
    logic [2:0] ctrl_q; // Intercept bit, legacy env, legacy isa
    logic [31:0] io_base_q; // Base of the I/O port block
    logic [31:0] fsr_q; // Floating-point status app register
    logic [31:0] fir_q; // Floating-point instruction app register
    logic [31:0] fdr_q; // Floating-point data app register
    logic fp_pending_q; // Scalar fault held pending
    logic [7:0] pend_vec_q; // Pending vector read register
    logic [2:0] last_txn_q; // Last transaction issued
    logic [31:0] last_addr_q; // Last memory reference address
    istatus_type ist_q; // Interruption status
    logic redirect_q;
    handler_type handler_q;
    logic atomic_q, split_q, memio_q, a20_q;
    bus_txn_type txn_q;

    // Decoded control bits
    wire intercept_bit = ctrl_q[`CTL_ATOMIC_INTERCEPT];
    wire legacy_env = ctrl_q[`CTL_LEGACY_ENV];
    wire legacy_isa = ctrl_q[`CTL_LEGACY_ISA];
    event_type kind;
    assign kind = event_type'(EV_KIND);

    // I/O block match, used by pin and a status view
    function automatic logic in_io_block(input logic [31:0] a,
                                         input logic [31:0] b);
        in_io_block = ((a ^ b) & `IO_BLOCK_MASK) == `ZERO32;
    endfunction

    // AXI write channel: take address and data in either order
    logic aw_have_q, w_have_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    wire wr_go = aw_have_q && w_have_q && !BVALID;
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= `ZERO32;
            ws_q <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_have_q <= 1'b1;
                aw_q <= AWADDR;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_have_q <= 1'b1;
                w_q <= WDATA;
                ws_q <= WSTRB;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Ready flops: one write in flight at a time
    always_ff @(posedge CLK) begin
        if (RST) begin
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
        end else begin
            AWREADY <= !aw_have_q && !(AWVALID && AWREADY) && !BVALID;
            WREADY <= !w_have_q && !(WVALID && WREADY) && !BVALID;
        end
    end

    // Known write offsets
    wire wr_ctrl = wr_go && aw_q == `OFS_CONTROL;
    wire wr_io = wr_go && aw_q == `OFS_IO_BASE;
    wire wr_known = wr_ctrl || wr_io;

    // Write response
    always_ff @(posedge CLK) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            BRESP <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Control and I/O base registers, low byte lane only for control
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q <= 3'h0;
            io_base_q <= IO_BASE_RESET;
        end else begin
            if (wr_ctrl && ws_q[0])
                ctrl_q <= w_q[2:0];
            if (wr_io) begin
                for (int i = 0; i < 4; i++)
                    if (ws_q[i])
                        io_base_q[i*8 +: 8] <= w_q[i*8 +: 8];
            end
        end
    end

    // Read channel: one read at a time, answer next cycle
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (ARADDR)
            `OFS_CONTROL: rd_mux = {29'h0, ctrl_q};
            `OFS_EVENT: rd_mux = {5'h0, handler_q, ist_q};
            `OFS_STATUS: rd_mux = {28'h0, fp_pending_q, memio_q,
                                   split_q, atomic_q};
            `OFS_FP_STATUS: rd_mux = fsr_q;
            `OFS_FP_INSTR: rd_mux = fir_q;
            `OFS_FP_DATA: rd_mux = fdr_q;
            `OFS_PENDING_VEC: rd_mux = {24'h0, pend_vec_q};
            `OFS_BUS_TXN: rd_mux = {29'h0, last_txn_q};
            `OFS_IO_BASE: rd_mux = io_base_q;
            `OFS_MEM_ADDR: rd_mux = last_addr_q;
            default: begin
                rd_mux = `ZERO32;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Read handshake
    always_ff @(posedge CLK) begin
        if (RST) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= `ZERO32;
            RRESP <= `RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RDATA <= rd_mux;
                RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // Event classification into handler and status
    handler_type h_d;
    istatus_type s_d;
    logic fp_report;
    always_comb begin
        h_d = H_NONE;
        s_d = '{vector: `VEC_ZERO, code: `CODE_ZERO};
        // Pending scalar fault reports on next scalar or media op or ISA jump
        fp_report = fp_pending_q && legacy_isa &&
                    (kind == EV_FP_SCALAR || kind == EV_FP_MEDIA ||
                     kind == EV_ISA_JUMP);
        if (EV_VALID) begin
            unique case (kind)
                EV_EXT_INT: h_d = H_EXTERNAL;
                EV_SW_INT: begin
                    h_d = H_LEGACY_INT;
                    s_d = '{vector: EV_VECTOR, code: EV_CODE};
                end
                EV_BAD_OP: begin
                    h_d = H_INTERCEPT_INST;
                    s_d.code = EV_CODE;
                end
                EV_GATE: begin
                    h_d = H_INTERCEPT_GATE;
                    s_d = '{vector: `VEC_GATE, code: EV_CODE};
                end
                EV_SYSFLAG: begin
                    h_d = H_INTERCEPT_FLAG;
                    s_d = '{vector: `VEC_SYSFLAG, code: EV_CODE};
                end
                EV_ATOMIC: begin
                    if (intercept_bit && !EV_CACHED) begin
                        h_d = H_INTERCEPT_LOCK;
                        s_d.vector = `VEC_LOCK;
                    end
                end
                EV_FP_PACKED: begin
                    // Precise fault, leaves pending scalar alone
                    h_d = H_FP_FAULT;
                    s_d = '{vector: EV_VECTOR, code: EV_CODE};
                end
                default: begin
                    if (fp_report)
                        h_d = H_FP_FAULT;
                end
            endcase
        end
    end

    // Redirection and status land together
    always_ff @(posedge CLK) begin
        if (RST) begin
            redirect_q <= 1'b0;
            handler_q <= H_NONE;
            ist_q <= '0;
        end else begin
            redirect_q <= h_d != H_NONE;
            if (h_d != H_NONE) begin
                handler_q <= h_d;
                ist_q <= s_d;
            end
        end
    end

    // Scalar pending fault and environment capture
    always_ff @(posedge CLK) begin
        if (RST) begin
            fp_pending_q <= 1'b0;
            fsr_q <= `ZERO32;
            fir_q <= `ZERO32;
            fdr_q <= `ZERO32;
        end else if (EV_VALID && kind == EV_FP_SCALAR && EV_CODE != 0) begin
            // New fault: set wins over the report of an old one
            fp_pending_q <= 1'b1;
            fsr_q <= EV_FP_STATUS;
            fir_q <= EV_FP_INSTR;
            fdr_q <= EV_FP_DATA;
        end else if (EV_VALID && fp_report) begin
            fp_pending_q <= 1'b0;
        end
        // Involuntary exits leave the fault pending
    end

    // Lock pins: only while executing legacy code
    always_ff @(posedge CLK) begin
        if (RST) begin
            atomic_q <= 1'b0;
            split_q <= 1'b0;
        end else begin
            atomic_q <= EV_VALID && kind == EV_ATOMIC && legacy_isa &&
                        !EV_CACHED && !intercept_bit;
            split_q <= EV_VALID && kind == EV_ATOMIC && legacy_isa &&
                       !EV_CACHED && !intercept_bit &&
                       EV_SPLIT;
        end
    end

    // Memory/IO indication and legacy pins
    always_ff @(posedge CLK) begin
        if (RST) begin
            memio_q <= 1'b0;
            a20_q <= 1'b0;
            last_addr_q <= `ZERO32;
        end else begin
            memio_q <= MEM_VALID &&
                       in_io_block(MEM_ADDR, io_base_q);
            if (MEM_VALID)
                last_addr_q <= MEM_ADDR;
            // Mask pin only honoured in the legacy environment
            a20_q <= legacy_env && ADDR_BIT20_MASK_PIN;
        end
    end

    // Special bus transactions, one-cycle code on BUS_TXN
    // No management-interrupt path exists at all
    bus_txn_type t_d;
    always_comb begin
        t_d = T_NONE;
        if (INT_ACK_READ)
            t_d = T_INT_ACK;
        else if (HALT_REQ)
            t_d = T_HALT;
        else if (SHUTDOWN_REQ && legacy_env)
            t_d = T_SHUTDOWN;
        else if (STOP_ACK_REQ)
            t_d = T_STOP_ACK;
        else if ((WRITEBACK_INVALIDATE_INSTRUCTION_EXEC || CACHE_INVALIDATE_INSTRUCTION_EXEC) && legacy_env)
            t_d = T_FLUSH;
    end

    // Sync follows the flush of a writeback-invalidate
    logic sync_due_q;
    always_ff @(posedge CLK) begin
        if (RST) begin
            txn_q <= T_NONE;
            sync_due_q <= 1'b0;
            last_txn_q <= 3'h0;
            pend_vec_q <= 8'h00;
        end else begin
            if (t_d == T_NONE && sync_due_q) begin
                txn_q <= T_SYNC;
                sync_due_q <= 1'b0;
            end else begin
                txn_q <= t_d;
                if (t_d == T_FLUSH && WRITEBACK_INVALIDATE_INSTRUCTION_EXEC)
                    sync_due_q <= 1'b1;
            end
            if (txn_q != T_NONE)
                last_txn_q <= txn_q;
            if (txn_q == T_INT_ACK)
                pend_vec_q <= INT_ACK_VECTOR;
        end
    end

    // Outputs straight from flops, FP_ERROR_PIN tied low
    assign REDIRECT = redirect_q;
    assign HANDLER = handler_q;
    assign ISTATUS = ist_q;
    assign ATOMIC_PIN = atomic_q;
    assign SPLIT_ATOMIC_PIN = split_q;
    assign MEM_IO_PIN = memio_q;
    assign FP_ERROR_PIN = 1'b0;
    assign A20_GATE = a20_q;
    assign BUS_TXN = txn_q;

    // Checks
    property p_ext;
        EV_VALID && kind == EV_EXT_INT |=> redirect_q &&
            handler_q == H_EXTERNAL && ist_q == '0;
    endproperty
    a_ext: assert property (p_ext) else $error("ext map");
    property p_sw;
        EV_VALID && kind == EV_SW_INT |=>
            ist_q.vector == $past(EV_VECTOR);
    endproperty
    a_sw: assert property (p_sw) else $error("sw vector");
    property p_lock;
        EV_VALID && kind == EV_ATOMIC && intercept_bit && !EV_CACHED
            |=> handler_q == H_INTERCEPT_LOCK && ist_q.vector == `VEC_LOCK
            && !atomic_q;
    endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_native;
        !$past(legacy_isa) |-> !atomic_q && !split_q;
    endproperty
    a_native: assert property (p_native) else $error("pins");
    property p_shut;
        txn_q == T_SHUTDOWN |-> $past(legacy_env);
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown");
    property p_sync;
        WRITEBACK_INVALIDATE_INSTRUCTION_EXEC && t_d == T_FLUSH ##1 t_d == T_NONE
            |=> txn_q == T_SYNC;
    endproperty
    a_sync: assert property (p_sync) else $error("sync");
    property p_packed;
        fp_pending_q && EV_VALID && kind == EV_FP_PACKED |=> fp_pending_q;
    endproperty
    a_packed: assert property (p_packed) else $error("packed");
    property p_invol;
        fp_pending_q && EV_VALID && kind == EV_INVOLUNTARY
            |=> fp_pending_q;
    endproperty
    a_invol: assert property (p_invol) else $error("wait");
    c_lock: cover property (handler_q == H_INTERCEPT_LOCK);
    c_sync: cover property (txn_q == T_SYNC);
    c_fp: cover property (handler_q == H_FP_FAULT);
endmodule

// ---- legacy_bus_model.sv ----
`timescale 1ns/1ps
module legacy_bus_model
    import legacy_map_pkg::*;
#(
    parameter logic [7:0] ACK_VEC = 8'h5A
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus side of the block
    input wire logic [2:0] bus_txn,
    input wire logic atomic_pin,
    input wire logic split_pin,
    // Answer to the block
    output logic [7:0] ack_vector,
    // External cache and lock state
    output logic cache_valid,
    output logic cache_dirty,
    output logic locked
);
    logic [7:0] noise_q; // Idle pattern on the vector lines
    // Changes every cycle so a stale vector can never pass
    always_ff @(posedge clk) begin
        if (rst) begin
            noise_q <= 8'hA5;
        end else begin
            noise_q <= ~noise_q + 8'h01;
        end
    end
    // Vector only in the acknowledge cycle
    assign ack_vector = (bus_txn == T_INT_ACK) ? ACK_VEC : noise_q;
    // Other masters kept off the bus while a lock pin is up
    always_ff @(posedge clk) begin
        if (rst) begin
            locked <= 1'b0;
        end else begin
            locked <= atomic_pin | split_pin;
        end
    end
    // Starts full and dirty, so both special cycles show an effect
    always_ff @(posedge clk) begin
        if (rst) begin
            cache_valid <= 1'b1;
            cache_dirty <= 1'b1;
        end else begin
            if (bus_txn == T_FLUSH) begin
                cache_valid <= 1'b0;
            end
            if (bus_txn == T_SYNC) begin
                cache_dirty <= 1'b0;
            end
        end
    end
endmodule

// ---- legacy_isa_interruption_bus_map_bench.sv ----
`timescale 1ns/1ps
`include "legacy_map_regs.svh"
module legacy_isa_interruption_bus_map_bench
    import legacy_map_pkg::*;
;
    localparam logic [7:0] VEC_ACK = 8'h5A; // Vector the model returns
    logic CLK = 1'b0, RST = 1'b1; // Clock and reset
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00; // Bus addresses
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [31:0] WDATA = 32'h0, MEM_ADDR = 32'h0; // Bus payloads
    logic EV_VALID = 0, EV_CACHED = 0, EV_SPLIT = 0, MEM_VALID = 0;
    logic [3:0] EV_KIND = 4'h0; // Event kind
    logic [7:0] EV_VECTOR = 8'h00; // Event vector
    logic [15:0] EV_CODE = 16'h0000; // Event detail code
    logic [5:0] req = 6'h00; // Firmware and cache pulses
    logic mask_pin = 0, ignore_numeric_error_pin_pin = 0; // Legacy pins in
    wire AWREADY, WREADY, BVALID, ARREADY, RVALID, REDIRECT;
    wire ATOMIC_PIN, SPLIT_ATOMIC_PIN, MEM_IO_PIN, FP_ERROR_PIN, A20_GATE;
    wire [1:0] BRESP, RRESP; // Responses
    wire [31:0] RDATA; // Read data
    wire [2:0] HANDLER, BUS_TXN; // Handler and transaction
    wire [23:0] ISTATUS; // Interruption status
    wire [7:0] ack_vec; // Vector from the model
    wire c_valid, c_dirty; // Model cache state
    int error_cnt = 0, compares = 0; // Tallies
    always #25 CLK = ~CLK;
    // Device under test
    legacy_map i_legacy_map (.CLK(CLK), .RST(RST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .EV_VALID(EV_VALID), .EV_KIND(EV_KIND), .EV_VECTOR(EV_VECTOR),
        .EV_CODE(EV_CODE), .EV_CACHED(EV_CACHED), .EV_SPLIT(EV_SPLIT),
        .EV_FP_STATUS(32'h11112222), .EV_FP_INSTR(32'h33334444),
        .EV_FP_DATA(32'h55556666), .MEM_VALID(MEM_VALID),
        .MEM_ADDR(MEM_ADDR), .INT_ACK_READ(req[0]), .HALT_REQ(req[1]),
        .SHUTDOWN_REQ(req[2]), .STOP_ACK_REQ(req[3]),
        .WRITEBACK_INVALIDATE_INSTRUCTION_EXEC(req[4]), .CACHE_INVALIDATE_INSTRUCTION_EXEC(req[5]),
        .ADDR_BIT20_MASK_PIN(mask_pin),
        .IGNORE_NUMERIC_ERROR_PIN(ignore_numeric_error_pin_pin), .INT_ACK_VECTOR(ack_vec),
        .REDIRECT(REDIRECT), .HANDLER(HANDLER), .ISTATUS(ISTATUS),
        .ATOMIC_PIN(ATOMIC_PIN), .SPLIT_ATOMIC_PIN(SPLIT_ATOMIC_PIN),
        .MEM_IO_PIN(MEM_IO_PIN), .FP_ERROR_PIN(FP_ERROR_PIN),
        .A20_GATE(A20_GATE), .BUS_TXN(BUS_TXN));
    // Far side: chipset and controller
    legacy_bus_model #(.ACK_VEC(VEC_ACK)) i_legacy_bus_model (.clk(CLK),
        .rst(RST), .bus_txn(BUS_TXN), .atomic_pin(ATOMIC_PIN),
        .split_pin(SPLIT_ATOMIC_PIN), .ack_vector(ack_vec),
        .cache_valid(c_valid), .cache_dirty(c_dirty), .locked());
    // Verdict and end of run
    task automatic end_of_test();
        $display("Compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One compare for every value
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait ran out
    task automatic hang(input int n);
        if (n > 40) begin
            chk("handshake", 32'h1, 32'h0);
            end_of_test();
        end
    endtask
    // Write both channels, release each when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            n++;
            hang(n);
        end while (BVALID !== 1'b1);
        BREADY <= 1'b0;
    endtask
    // Read one word and compare data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            n++;
            hang(n);
        end while (RVALID !== 1'b1);
        chk("RDATA", e, RDATA);
        chk("RRESP", 32'(er), 32'(RRESP));
        RREADY <= 1'b0;
    endtask
    // One event pulse, answer landed on return
    task automatic ev(input event_type k, input logic [7:0] v,
                      input logic [15:0] c, input logic ca, sp);
        @(posedge CLK);
        EV_VALID <= 1'b1;
        EV_KIND <= k;
        EV_VECTOR <= v;
        EV_CODE <= c;
        EV_CACHED <= ca;
        EV_SPLIT <= sp;
        @(posedge CLK);
        EV_VALID <= 1'b0;
        @(negedge CLK);
    endtask
    // Redirection, handler and status seen together
    task automatic hchk(input logic r, input handler_type h,
                        input logic [23:0] s);
        chk("REDIRECT", 32'(r), 32'(REDIRECT));
        if (r) chk("HANDLER", 32'(h), 32'(HANDLER));
        if (r) chk("ISTATUS", 32'(s), 32'(ISTATUS));
    endtask
    // Memory reference, judged one cycle later
    task automatic mem(input logic [31:0] a, input logic e);
        @(posedge CLK);
        MEM_VALID <= 1'b1;
        MEM_ADDR <= a;
        @(posedge CLK);
        MEM_VALID <= 1'b0;
        @(negedge CLK);
        chk("MEM_IO_PIN", 32'(e), 32'(MEM_IO_PIN));
    endtask
    // Request pulse, two cycles of code
    task automatic txn(input logic [31:0] ctl, input logic [5:0] r,
                       input bus_txn_type e1, e2);
        wr(`OFS_CONTROL, ctl);
        @(posedge CLK);
        req <= r;
        @(posedge CLK);
        req <= 6'h00;
        @(negedge CLK);
        chk("BUS_TXN", 32'(e1), 32'(BUS_TXN));
        @(negedge CLK);
        chk("BUS_TXN next", 32'(e2), 32'(BUS_TXN));
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
        rd(`OFS_CONTROL, `ZERO32, `RESP_OKAY);
        rd(`OFS_IO_BASE, `ZERO32, `RESP_OKAY);
        rd(8'h3C, `ZERO32, `RESP_SLVERR);
        // Mapping table, wide fields
        ev(EV_EXT_INT, 8'hFF, 16'h1234, 0, 0);
        hchk(1, H_EXTERNAL, 24'h000000);
        ev(EV_SW_INT, 8'hFF, 16'h00A5, 0, 0);
        hchk(1, H_LEGACY_INT, 24'hFF00A5);
        ev(EV_BAD_OP, 8'h33, 16'h0042, 0, 0);
        hchk(1, H_INTERCEPT_INST, 24'h000042);
        ev(EV_GATE, 8'h33, 16'h0007, 0, 0);
        hchk(1, H_INTERCEPT_GATE, 24'h010007);
        ev(EV_SYSFLAG, 8'h00, 16'hFFFF, 0, 0);
        hchk(1, H_INTERCEPT_FLAG, 24'h02FFFF);
        // Atomic references per control setting
        wr(`OFS_CONTROL, 32'h5);
        ev(EV_ATOMIC, 8'h77, 16'h0055, 0, 0);
        hchk(1, H_INTERCEPT_LOCK, 24'h040000);
        chk("ATOMIC_PIN", 0, 32'(ATOMIC_PIN));
        wr(`OFS_CONTROL, 32'h4);
        ev(EV_ATOMIC, 8'h00, 16'h0000, 0, 1);
        chk("ATOMIC_PIN", 1, 32'(ATOMIC_PIN));
        chk("SPLIT_ATOMIC_PIN", 1, 32'(SPLIT_ATOMIC_PIN));
        ev(EV_ATOMIC, 8'h00, 16'h0000, 1, 0);
        chk("ATOMIC_PIN", 0, 32'(ATOMIC_PIN));
        wr(`OFS_CONTROL, 32'h0);
        ev(EV_ATOMIC, 8'h00, 16'h0000, 0, 1);
        chk("ATOMIC_PIN", 0, 32'(ATOMIC_PIN));
        chk("SPLIT_ATOMIC_PIN", 0, 32'(SPLIT_ATOMIC_PIN));
        // Delayed scalar faults
        wr(`OFS_CONTROL, 32'h4);
        ev(EV_FP_SCALAR, 8'h00, 16'h0001, 0, 0);
        hchk(0, H_NONE, 24'h0);
        rd(`OFS_FP_STATUS, 32'h11112222, `RESP_OKAY);
        rd(`OFS_FP_INSTR, 32'h33334444, `RESP_OKAY);
        rd(`OFS_FP_DATA, 32'h55556666, `RESP_OKAY);
        ev(EV_FP_PACKED, 8'h13, 16'h0003, 0, 0);
        hchk(1, H_FP_FAULT, 24'h130003);
        ev(EV_FP_MEDIA, 8'h00, 16'h0000, 0, 0);
        hchk(1, H_FP_FAULT, 24'h0);
        ev(EV_FP_MEDIA, 8'h00, 16'h0000, 0, 0);
        hchk(0, H_NONE, 24'h0);
        ev(EV_FP_SCALAR, 8'h00, 16'h0002, 0, 0);
        ev(EV_INVOLUNTARY, 8'h00, 16'h0000, 0, 0);
        hchk(0, H_NONE, 24'h0);
        ev(EV_ISA_JUMP, 8'h00, 16'h0000, 0, 0);
        hchk(1, H_FP_FAULT, 24'h0);
        chk("FP_ERROR_PIN", 0, 32'(FP_ERROR_PIN));
        // I/O port block edges in both environments
        wr(`OFS_IO_BASE, 32'h40000000);
        for (int env = 0; env < 2; env++) begin
            wr(`OFS_CONTROL, 32'(env * 2));
            mem(32'h40000000, 1);
            mem(32'h43FFFFFC, 1);
            mem(32'h44000000, 0);
            mem(32'h3FFFFFFC, 0);
        end
        // Native environment ignores the legacy pins
        wr(`OFS_CONTROL, 32'h0);
        mask_pin <= 1'b1;
        ignore_numeric_error_pin_pin <= 1'b1;
        repeat (2) @(negedge CLK);
        chk("A20_GATE", 0, 32'(A20_GATE));
        chk("FP_ERROR_PIN", 0, 32'(FP_ERROR_PIN));
        // Special bus cycles
        txn(32'h0, 6'h01, T_INT_ACK, T_NONE);
        rd(`OFS_PENDING_VEC, 32'(VEC_ACK), `RESP_OKAY);
        txn(32'h0, 6'h02, T_HALT, T_NONE);
        txn(32'h0, 6'h08, T_STOP_ACK, T_NONE);
        txn(32'h0, 6'h04, T_NONE, T_NONE);
        txn(32'h0, 6'h30, T_NONE, T_NONE);
        chk("cache_valid", 1, 32'(c_valid));
        txn(32'h2, 6'h04, T_SHUTDOWN, T_NONE);
        txn(32'h2, 6'h20, T_FLUSH, T_NONE);
        chk("cache_valid", 0, 32'(c_valid));
        chk("cache_dirty", 1, 32'(c_dirty));
        txn(32'h2, 6'h10, T_FLUSH, T_SYNC);
        @(negedge CLK);
        chk("cache_dirty", 0, 32'(c_dirty));
        end_of_test();
    end
endmodule
